// *** design/gdp_counter_map.svh ***
// Constants for the gated delayed-pulse counter.
// Assumes inclusion by name from the design files.
// Behaviour
// R1 - Level-gated mode counts only while the counter is armed.
// R2 - Level-gated mode counts source edges only while the gate is active.
// R3 - First count end reloads the counter from the hold register.
// R4 - Level-gated second count end reloads from load register, then disarms.
// R5 - Edge-triggered mode waits for a gate edge before counting.
// R6 - Edge-triggered mode ignores gate edges while disarmed.
// R7 - Edge-triggered counting starts on first source edge after trigger.
// R8 - Edge-triggered mode disarms itself after the second count end.
// R9 - Host must arm first, then apply gate edge, to restart.
// R10 - After trigger, gate is ignored until second count end.
// R11 - Count end follows 0001 down, 9999 BCD up, FFFF binary up.
// R12 - Qualified source edge is active-going while gate is active.
// R13 - First count end ends delay, second ends pulse; output toggles.
`ifndef GDP_COUNTER_MAP_SVH
`define GDP_COUNTER_MAP_SVH
`define CNT_W          16
`define CNT_DOWN_END   16'h0001
`define CNT_BCD_END    16'h9999
`define CNT_BIN_END    16'hFFFF
`define MODE_LEVEL     1'b0
`define MODE_EDGE      1'b1
`endif

// *** design/gdp_counter_pkg.sv ***
// Types for the gated delayed-pulse counter.
// Assumes the map header defines widths.
package gdp_counter_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_DELAY = 2'b10,
      ST_PULSE = 2'b11
   } run_state_t;
endpackage : gdp_counter_pkg

// *** design/gated_delayed_pulse_counter.sv ***
// Delayed-pulse one-shot counter, level-gated and edge-triggered variants.
// Assumes source and gate come from pins; commands are one-cycle pulses
// from logic on clk.
`timescale 1ns/1ps
`include "gdp_counter_map.svh"
module gated_delayed_pulse_counter (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               counter_mode_bits, // 0 level, 1 edge
   input  wire logic               count_up,
   input  wire logic               count_bcd,
   input  wire logic               source_pin,
   input  wire logic               gate_pin,
   input  wire logic               arm_cmd,
   input  wire logic               disarm_cmd,
   input  wire logic               load_cmd,
   input  wire logic [`CNT_W-1:0]  load_value,
   input  wire logic [`CNT_W-1:0]  hold_value,
   output logic [`CNT_W-1:0]       count_value,
   output logic                    armed,
   output logic                    pulse_out,
   output logic                    count_end_event
);
   import gdp_counter_pkg::*;

   // Binary or BCD step of a 16-bit value by one, up or down
   function automatic logic [`CNT_W-1:0] step(input logic [`CNT_W-1:0] v,
                                            input logic up,
                                            input logic bcd);
      logic [`CNT_W-1:0] r;
      logic              carry;
      r = v;
      carry = 1'b1;
      if (!bcd) begin
         r = up ? v + 16'h0001 : v - 16'h0001;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (carry) begin
               if (up) begin
                  carry = (v[i*4 +: 4] == 4'h9);
                  r[i*4 +: 4] = carry ? 4'h0 : v[i*4 +: 4] + 4'h1;
               end else begin
                  carry = (v[i*4 +: 4] == 4'h0);
                  r[i*4 +: 4] = carry ? 4'h9 : v[i*4 +: 4] - 4'h1;
               end
            end
         end
      end
      return r;
   endfunction : step

   // Count-end value for the selected direction and code
   function automatic logic [`CNT_W-1:0] end_of_range(input logic up,
                                                     input logic bcd);
      logic [`CNT_W-1:0] e;
      e = `CNT_DOWN_END;
      if (up && bcd) begin
         e = `CNT_BCD_END;
      end else if (up) begin
         e = `CNT_BIN_END;
      end
      return e;
   endfunction : end_of_range

   // Pin synchronisers
   // Only the second flop of each pair feeds logic; the first may be
   // metastable. Everything clears to the idle low level of the pins, so
   // a pin that idles low shows no false edge after reset.
   logic [1:0] src_sync_r;
   logic [1:0] gate_sync_r;
   logic       src_prev_r;
   logic       gate_prev_r;

   // Source pin synchroniser and edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_sync_r <= 2'b00;
         src_prev_r <= 1'b0;
      end else begin
         src_sync_r <= {src_sync_r[0], source_pin};
         src_prev_r <= src_sync_r[1];
      end
   end

   // Gate pin synchroniser and edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate_sync_r <= 2'b00;
         gate_prev_r <= 1'b0;
      end else begin
         gate_sync_r <= {gate_sync_r[0], gate_pin};
         gate_prev_r <= gate_sync_r[1];
      end
   end

   // Edge detection on synchronised signals
   wire src_rise  = src_sync_r[1] & ~src_prev_r;
   wire gate_lvl  = gate_sync_r[1];
   wire gate_rise = gate_sync_r[1] & ~gate_prev_r;

   run_state_t        state_r;
   run_state_t        state_nxt;
   logic [`CNT_W-1:0] count_r;
   logic [`CNT_W-1:0] count_nxt;
   logic              out_r;
   logic              out_nxt;
   logic              end_r;
   logic              end_nxt;

   // R11 end-value select
   wire [`CNT_W-1:0] end_value = end_of_range(count_up, count_bcd);
   wire at_end = (count_r == end_value);
   wire counting = (state_r == ST_DELAY) || (state_r == ST_PULSE);
   // R12 qualified edge in level mode
   wire lvl_edge = src_rise & gate_lvl;
   // R2 R10 edge selection per mode
   wire do_count = counting &
                   ((counter_mode_bits == `MODE_EDGE) ? src_rise : lvl_edge);

   // Sequencing of arm, trigger, delay and pulse phases
   // A count end replaces the step on the same counted edge, so the
   // counter never shows the wrapped value. Load is honoured only while
   // idle: loading a running counter would corrupt the delay or pulse.
   // Disarm is applied last to the phase only, so it wins over arm; a same-cycle count still updates counter and output.
   // Direction and code must not change while armed; the end value is
   // decoded from them on every cycle.
   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      out_nxt   = out_r;
      end_nxt   = 1'b0;
      if (load_cmd && state_r == ST_IDLE) begin
         count_nxt = load_value;
      end
      case (state_r)
         ST_IDLE: begin
            // R6 R9 only arm leaves idle
            if (arm_cmd) begin
               // R1 level mode counts once armed
               state_nxt = (counter_mode_bits == `MODE_EDGE) ? ST_WAIT
                                                              : ST_DELAY;
            end
         end
         ST_WAIT: begin
            // R5 R7 trigger gate edge
            if (gate_rise) begin
               state_nxt = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (do_count) begin
               if (at_end) begin
                  // R3 R13 first count end
                  count_nxt = hold_value;
                  out_nxt   = ~out_r;
                  end_nxt   = 1'b1;
                  state_nxt = ST_PULSE;
               end else begin
                  count_nxt = step(count_r, count_up, count_bcd);
               end
            end
         end
         ST_PULSE: begin
            if (do_count) begin
               if (at_end) begin
                  // R4 R8 R13 second count end
                  count_nxt = load_value;
                  out_nxt   = ~out_r;
                  end_nxt   = 1'b1;
                  state_nxt = ST_IDLE;
               end else begin
                  count_nxt = step(count_r, count_up, count_bcd);
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (disarm_cmd) begin
         state_nxt = ST_IDLE;
      end
   end

   // Phase register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Count register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_nxt;
      end
   end

   // Toggled output register, low after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   // One-cycle count end pulse register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         end_r <= 1'b0;
      end else begin
         end_r <= end_nxt;
      end
   end

   // Outputs straight from flip-flops, except armed, decoded from the phase register

   assign count_value     = count_r;
   assign armed           = (state_r != ST_IDLE);
   assign pulse_out       = out_r;
   assign count_end_event = end_r;
endmodule : gated_delayed_pulse_counter

// *** dv/gdp_chk.sv ***
// Port assertions for the delayed-pulse counter.
// Assumes bind to the counter; one clock, async reset.
`timescale 1ns/1ps
`include "gdp_counter_map.svh"
module gdp_chk (
   input wire logic clk, rst, counter_mode_bits, count_up, count_bcd,
   input wire logic source_pin, gate_pin, arm_cmd, disarm_cmd, load_cmd,
   input wire logic [`CNT_W-1:0] load_value, hold_value, count_value,
   input wire logic armed, pulse_out, count_end_event
);
   wire logic [`CNT_W-1:0] end_v = !count_up ? `CNT_DOWN_END :
      count_bcd ? `CNT_BCD_END : `CNT_BIN_END;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_lvl_shut; (armed && !counter_mode_bits && !gate_pin) [*8];
   endsequence
   sequence s_edge_wait; $rose(armed) && counter_mode_bits ##1 !gate_pin [*5];
   endsequence
   a_arm_taken: assert property (arm_cmd && !armed |=> armed)
      else $error("arm lost");
   a_idle_frozen: assert property (
      !armed && !load_cmd |=> $stable(count_value)) else $error("idle count");
   a_gate_shut: assert property (
      s_lvl_shut |=> count_value == $past(count_value, 4)) else $error("gate");
   a_first_reload: assert property (
      count_end_event && pulse_out |-> count_value == hold_value && armed)
      else $error("first end");
   a_second_reload: assert property (
      count_end_event && !pulse_out |-> count_value == load_value && !armed)
      else $error("second end");
   a_edge_wait: assert property (
      s_edge_wait |-> count_value == $past(count_value, 5)) else $error("wait");
   a_end_value: assert property (
      count_end_event |-> $past(count_value) == $past(end_v)) else $error("end");
   a_end_toggle: assert property (
      count_end_event == (pulse_out != $past(pulse_out))) else $error("out");
endmodule : gdp_chk
bind gated_delayed_pulse_counter gdp_chk u_chk (.*);

// *** dv/pin_model.sv ***
// Drives the source and gate pins.
// Assumes calls from the clk domain.
`timescale 1ns/1ps
module pin_model (
   input  wire logic clk,
   output logic      source_pin,
   output logic      gate_pin
);
   initial {source_pin, gate_pin} = 2'h0;
   task automatic src(input int n);
      repeat (n) begin
         @(posedge clk) source_pin <= 1'h1;
         repeat (4) @(posedge clk);
         source_pin <= 1'h0;
         repeat (4) @(posedge clk);
      end
   endtask : src
   task automatic gate(input logic v);
      @(posedge clk) gate_pin <= v;
      repeat (4) @(posedge clk);
   endtask : gate
endmodule : pin_model

// *** dv/tb_top.sv ***
// Bench for the delayed-pulse counter.
// Assumes pin_model drives the pins.
`timescale 1ns/1ps
`include "gdp_counter_map.svh"
module tb_top;
   logic clk, rst, md, up, bcd, ar, ds, ld;
   logic [`CNT_W-1:0] lv, hv, cnt;
   logic armed, po, ce, sp, gp;
   int n_fail = 0, checks = 0, cyc = 0;
   initial clk = 1'b0;
   always #10 clk = ~clk;
   pin_model pm (.clk(clk), .source_pin(sp), .gate_pin(gp));
   gated_delayed_pulse_counter dut (.clk(clk), .rst(rst),
      .counter_mode_bits(md), .count_up(up), .count_bcd(bcd),
      .source_pin(sp), .gate_pin(gp), .arm_cmd(ar), .disarm_cmd(ds),
      .load_cmd(ld), .load_value(lv), .hold_value(hv), .count_value(cnt),
      .armed(armed), .pulse_out(po), .count_end_event(ce));
   task automatic final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] g, e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask : chk
   // Command pulse: load, arm, disarm
   task automatic cmd(input logic [2:0] c);
      @(posedge clk) {ld, ar, ds} <= c;
      @(posedge clk) {ld, ar, ds} <= 3'h0;
      repeat (2) @(posedge clk);
   endtask : cmd
   task automatic t_ends;
      logic [15:0] st [3] = '{16'h0002, 16'h9998, 16'hFFFE};
      pm.gate(1'h1);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) {up, bcd, lv, hv} <= {i > 0, i == 1, st[i], 16'h0055};
         cmd(3'h4);
         cmd(3'h2);
         pm.src(2);
         chk(cnt, 16'h0055);
         cmd(3'h1);
         @(posedge clk) rst <= 1'h1;
         @(posedge clk) rst <= 1'h0;
      end
      pm.gate(1'h0);
   endtask : t_ends
   task automatic t_level;
      @(posedge clk) {up, lv, hv} <= {1'h0, 16'h0003, 16'h0002};
      cmd(3'h4);
      cmd(3'h2);
      pm.src(2);
      chk(cnt, 16'h0003);
      pm.gate(1'h1);
      pm.src(3);
      chk(cnt, 16'h0002);
      pm.src(3);
      chk(16'(armed | po), 16'h0000);
      pm.src(1);
      chk(cnt, 16'h0003);
      pm.gate(1'h0);
   endtask : t_level
   task automatic t_edge;
      @(posedge clk) md <= 1'h1;
      pm.gate(1'h1);
      pm.gate(1'h0);
      cmd(3'h2);
      pm.src(2);
      chk(cnt, 16'h0003);
      pm.gate(1'h1);
      pm.gate(1'h0);
      pm.src(1);
      chk(cnt, 16'h0002);
      pm.src(4);
      chk(cnt, 16'h0003);
      chk(16'(armed), 16'h0000);
   endtask : t_edge
   initial begin
      {rst, md, up, bcd, ar, ds, ld} <= 7'h40;
      {lv, hv} <= 32'h0000_0000;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_ends();
      t_level();
      t_edge();
      final_report();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
endmodule : tb_top
